// ### design/irq_event_pkg.sv
// irq_event_pkg: constants and carriers for the serial interrupt event unit
// assumes a classic wishbone slave with 32-bit data, one word per register
package irq_event_pkg;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [3:0] addr_enable_c   = 4'h4;
  localparam logic [3:0] addr_event_c    = 4'h8;
  localparam logic [3:0] addr_mode_c     = 4'hc;

  // ==========================================================================
  // field layout
  localparam int rx_bit_c      = 0;
  localparam int tx_bit_c      = 1;
  localparam int line_bit_c    = 2;
  localparam int modem_bit_c   = 3;
  localparam int dma_bit_c     = 4;
  localparam int empty_bit_c   = 5;
  localparam logic [7:0] ier_legacy_mask_c = 8'h0f;
  localparam logic [7:0] ier_ext_mask_c    = 8'h3f;
  localparam logic [7:0] ier_reset_c       = 8'h00;

  // priority codes, bits 3..0
  localparam logic [3:0] code_none_c    = 4'h1;
  localparam logic [3:0] code_line_c    = 4'h6;
  localparam logic [3:0] code_rx_c      = 4'h4;
  localparam logic [3:0] code_timeout_c = 4'hc;
  localparam logic [3:0] code_tx_c      = 4'h2;
  localparam logic [3:0] code_modem_c   = 4'h0;
  localparam logic [1:0] fifos_on_c     = 2'h3;

  // tx threshold levels for codes 00..11
  localparam logic [4:0] tx_level_0_c = 5'h01;
  localparam logic [4:0] tx_level_1_c = 5'h03;
  localparam logic [4:0] tx_level_2_c = 5'h09;
  localparam logic [4:0] tx_level_3_c = 5'h0d;

  // timeout: four character times
  localparam int char_times_c = 4;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic       rx_full;       // holding reg full or level at/above threshold
    logic       rx_char_held;  // at least one char in receiver
    logic       rx_activity;   // char entered or left the rx fifo
    logic       char_tick;     // one pulse per character time
    logic [4:0] tx_level;      // tx fifo content
    logic       thr_empty;     // holding register / fifo empty
    logic       tx_idle;       // transmitter and fifo empty
    logic       line_err;      // parity, framing, overrun or break pulse
    logic       tx_underrun;   // consumer infrared underrun pulse
    logic       modem_change;  // cts/dsr/dcd change or ri rise pulse
    logic       dma_count;     // dma terminal count pulse
  } src_t;

  typedef struct packed {
    logic rd_rx_data;
    logic wr_tx_data;
    logic rd_line_status;
    logic rd_modem_status;
  } port_access_t;

endpackage

// ### design/serial_ir_interrupt_event_unit.sv
// serial_ir_interrupt_event_unit: interrupt enable and event identification
// assumes sources are synchronous pulses/levels from the serial core
// assumes acc_i pulses mark the core's own register accesses
// assumes the bus master holds a request until it sees ack
//
// Functional notes
// - reset gives legacy layout, enables cleared
// - bit0 gates rx level and timeout
// - bit1 gates tx low level code 0010
// - bit2 gates line status code 0110
// - bit3 gates modem status code 0000
// - extended bit0 rx threshold or timeout
// - extended bit1 tx below threshold or empty
// - extended bit4 dma count when dma on
// - extended bit5 tx idle; bits 7,6 reserved
// - infrared bit2 also gates tx underrun
// - read gives events, write gives fifo control
// - legacy mode shows highest of four priorities
// - bit0 low when pending, idle reads 0001
// - timeout bit only with fifos enabled or infrared on
// - bits 7,6 show fifo enable, 5,4 zero
// - line status highest, cleared by status read
// - rx level second, cleared by read/drop
// - timeout after four idle character times
// - tx low third, cleared by event read or tx data write
// - modem lowest, cleared by modem status read
// - extended flags individual, event read clears dma only with legacy_dma_i high
// - rx/tx flags follow fifo use
// - upper enable bits only in extended mode
// - tx threshold levels 1,3,9,13
`timescale 1ns/1ps
module serial_ir_interrupt_event_unit (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic                        we_i,
  input  wire logic [3:0]                  sel_i,
  input  wire logic [3:0]                  adr_i,
  input  wire logic [31:0]                 dat_i,
  output logic      [31:0]                 dat_o,
  output logic                             ack_o,
  input  wire irq_event_pkg::src_t         src_i,
  input  wire irq_event_pkg::port_access_t acc_i,
  input  wire logic                        legacy_dma_i,
  output logic      [7:0]                  fifo_control_o,
  output logic                             fifo_control_wr_o,
  output logic                             irq_o
);
  import irq_event_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]  interrupt_enable;
    logic [7:0]  fifo_control;
    logic        extended_select;
    logic        infrared;
    logic        dma_on;
    logic        tx_dir;
    logic        line_ev;
    logic        tx_ev;
    logic        tx_low_q;
    logic        modem_ev;
    logic        dma_ev;
    logic        timeout_ev;
    logic [2:0]  idle_chars;
    logic [31:0] rdata;
    logic        ack;
    logic        fcr_wr;
  } state_t;

  state_t r;
  state_t next_r;

  function automatic logic [4:0] tx_threshold(input logic [1:0] code);
    unique case (code)
      2'b00: tx_threshold = tx_level_0_c;
      2'b01: tx_threshold = tx_level_1_c;
      2'b10: tx_threshold = tx_level_2_c;
      default: tx_threshold = tx_level_3_c;
    endcase
  endfunction

  // register select on the byte address
  function automatic logic reg_hit(input logic [3:0] adr,
                                   input logic [3:0] base);
    reg_hit = (adr == base);
  endfunction

  // ==========================================================================
  // mode view
  logic       legacy_mode;
  logic       ir_transmit;

  always_comb begin
    legacy_mode = ~r.extended_select;
    // consumer infrared reports an underrun only while it transmits
    ir_transmit = r.infrared & r.tx_dir;
  end

  // ==========================================================================
  // bus decode
  logic       bus_take;
  logic       bus_read;

  always_comb begin
    // ack in flight blocks a second take of a request that is still held
    bus_take = cyc_i & stb_i & ~r.ack;
    bus_read = bus_take & ~we_i;
  end

  // ==========================================================================
  // event view
  logic       fifo_en;
  logic       rx_flag;
  logic       tx_low;
  logic       empty_flag;
  logic [7:0] pend;
  logic [7:0] enab;
  logic [7:0] legacy_eir;
  logic [7:0] ext_eir;
  logic [7:0] eir_view;
  logic [3:0] code;
  logic       req;
  logic       rd_event;
  logic [7:0] wr_byte;

  always_comb begin
    fifo_en    = r.fifo_control[0] | r.infrared;
    tx_low     = fifo_en
                 ? (src_i.tx_level < tx_threshold(r.fifo_control[5:4]))
                 : src_i.thr_empty;
    rx_flag    = src_i.rx_full | (fifo_en & r.timeout_ev);
    empty_flag = src_i.tx_idle;
    // extended flags set regardless of enables
    pend = 8'h00;
    pend[rx_bit_c]    = rx_flag;
    pend[tx_bit_c]    = r.tx_ev;
    pend[line_bit_c]  = r.line_ev;
    pend[modem_bit_c] = r.modem_ev;
    pend[dma_bit_c]   = r.dma_ev;
    pend[empty_bit_c] = empty_flag;
    ext_eir = pend;
    enab = r.interrupt_enable;
    enab[dma_bit_c] = r.interrupt_enable[dma_bit_c] & r.dma_on;
    // legacy priority encoder
    if (r.line_ev && r.interrupt_enable[line_bit_c]) begin
      code = code_line_c;
    end else if (fifo_en && r.timeout_ev && r.interrupt_enable[rx_bit_c]) begin
      code = code_timeout_c;
    end else if (src_i.rx_full && r.interrupt_enable[rx_bit_c]) begin
      code = code_rx_c;
    end else if (r.tx_ev && r.interrupt_enable[tx_bit_c]) begin
      code = code_tx_c;
    end else if (r.modem_ev && r.interrupt_enable[modem_bit_c]) begin
      code = code_modem_c;
    end else begin
      code = code_none_c;
    end
    legacy_eir = {(r.fifo_control[0] ? fifos_on_c : 2'h0), 2'h0, code};
    eir_view   = r.extended_select ? ext_eir : legacy_eir;
    rd_event   = bus_read & reg_hit(adr_i, addr_event_c);
    wr_byte    = dat_i[7:0];
  end

  // ==========================================================================
  // flag causes
  logic       line_set;
  logic       line_clr;
  logic       modem_set;
  logic       modem_clr;
  logic       tx_set;
  logic       tx_clr;
  logic       dma_set;
  logic       dma_clr;
  logic       idle_restart;
  logic       idle_count;
  logic       timeout_set;
  logic       timeout_clr;

  always_comb begin
    line_set     = src_i.line_err
                   | (ir_transmit & src_i.tx_underrun);
    line_clr     = acc_i.rd_line_status;
    modem_set    = src_i.modem_change;
    modem_clr    = acc_i.rd_modem_status;
    // tx low is raised on entry to the low level, so the read that
    // clears it in legacy mode does not see it return at once
    tx_set       = tx_low & (~r.tx_low_q | r.extended_select)
                   & ~acc_i.wr_tx_data;
    tx_clr       = acc_i.wr_tx_data
                   | (rd_event & legacy_mode & (code == code_tx_c))
                   | (r.extended_select & ~tx_low);
    dma_set      = src_i.dma_count;
    dma_clr      = rd_event & r.extended_select & legacy_dma_i;
    idle_restart = ~src_i.rx_char_held | src_i.rx_activity
                   | acc_i.rd_rx_data;
    idle_count   = src_i.char_tick
                   & (r.idle_chars < 3'(char_times_c));
    timeout_set  = src_i.rx_char_held & ~src_i.rx_activity
                   & src_i.char_tick
                   & (r.idle_chars == 3'(char_times_c - 1));
    timeout_clr  = acc_i.rd_rx_data;
  end

  // ==========================================================================
  // interrupt request
  logic [7:0] req_terms;

  always_comb begin
    // legacy mode holds enables 4 and 5 clear, so one sum serves both
    req_terms = pend & enab;
    req       = req_terms != 8'h00;
  end

  // ==========================================================================
  // read back
  logic [31:0] read_word;

  always_comb begin
    // unmapped addresses read zero
    unique case (adr_i)
      addr_enable_c: read_word = {24'h0, r.interrupt_enable};
      addr_event_c:  read_word = {24'h0, eir_view};
      addr_mode_c:   read_word = {28'h0, r.tx_dir, r.dma_on,
                                  r.infrared, r.extended_select};
      default:       read_word = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // enable register masks
  logic [7:0] ier_keep;
  logic [7:0] ier_wr_value;
  logic [7:0] ier_mode_value;

  always_comb begin
    // enables 4 and 5 exist only in extended mode; 6 and 7 never do
    ier_keep       = r.extended_select ? ier_ext_mask_c : ier_legacy_mask_c;
    ier_wr_value   = wr_byte & ier_keep;
    // leaving extended mode drops the upper enables at once
    ier_mode_value = r.interrupt_enable & ier_legacy_mask_c;
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_r        = r;
    next_r.ack    = bus_take;
    next_r.fcr_wr = 1'b0;
    next_r.rdata  = 32'h0000_0000;

    // pending flags: a cause in the clearing cycle keeps the flag set, except a tx data write always clears tx
    if (line_clr) begin
      next_r.line_ev = 1'b0;
    end
    if (line_set) begin
      next_r.line_ev = 1'b1;
    end
    if (modem_clr) begin
      next_r.modem_ev = 1'b0;
    end
    if (modem_set) begin
      next_r.modem_ev = 1'b1;
    end
    if (tx_clr) begin
      next_r.tx_ev = 1'b0;
    end
    if (tx_set) begin
      next_r.tx_ev = 1'b1;
    end
    next_r.tx_low_q = tx_low;
    if (dma_clr) begin
      next_r.dma_ev = 1'b0;
    end
    if (dma_set) begin
      next_r.dma_ev = 1'b1;
    end
    if (idle_restart) begin
      next_r.idle_chars = 3'h0;
    end else if (idle_count) begin
      next_r.idle_chars = r.idle_chars + 3'h1;
    end
    if (timeout_clr) begin
      next_r.timeout_ev = 1'b0;
    end
    if (timeout_set) begin
      next_r.timeout_ev = 1'b1;
    end

    // bus access on the request cycle
    if (bus_take) begin
      if (we_i) begin
        if (sel_i[0]) begin
          unique case (adr_i)
            addr_enable_c: begin
              next_r.interrupt_enable = ier_wr_value;
            end
            addr_event_c: begin
              next_r.fifo_control    = wr_byte;
              next_r.fcr_wr = 1'b1;
            end
            addr_mode_c: begin
              next_r.extended_select = wr_byte[0];
              next_r.infrared        = wr_byte[1];
              next_r.dma_on          = wr_byte[2];
              next_r.tx_dir          = wr_byte[3];
              if (!wr_byte[0]) begin
                next_r.interrupt_enable = ier_mode_value;
              end
            end
            default: begin
            end
          endcase
        end
      end else begin
        next_r.rdata = read_word;
      end
    end

    // reset overrides every update above
    if (rst_i) begin
      next_r     = '0;
      next_r.interrupt_enable = ier_reset_c;
    end
  end

  always_ff @(posedge clk_i) begin
    r <= next_r;
  end

  // ==========================================================================
  // outputs
  assign dat_o             = r.rdata;
  assign ack_o             = r.ack;
  assign fifo_control_o    = r.fifo_control;
  assign fifo_control_wr_o = r.fcr_wr;
  assign irq_o             = req;

endmodule

// ### tb/irq_event_checker.sv
// irq_event_checker: bus and event-byte properties of the interrupt unit
// assumes it is bound to serial_ir_interrupt_event_unit
`timescale 1ns/1ps
module irq_event_checker
  import irq_event_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  sel_i,
  input wire logic [3:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [7:0]  fifo_control_o,
  input wire logic        fifo_control_wr_o,
  input wire logic        irq_o
);
  logic taken;
  logic fcr_wr;
  logic rd_evt;
  logic rd_ier;
  logic ext;
  assign taken = cyc_i && stb_i && !ack_o;
  assign fcr_wr = taken && we_i && sel_i[0] && adr_i == addr_event_c;
  // ==========================================================================
  // access tracking
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_evt <= 1'b0;
      rd_ier <= 1'b0;
      ext    <= 1'b0;
    end else begin
      rd_evt <= taken && !we_i && adr_i == addr_event_c;
      rd_ier <= taken && !we_i && adr_i == addr_enable_c;
      if (taken && we_i && sel_i[0] && adr_i == addr_mode_c) begin
        ext <= dat_i[0];
      end
    end
  end
  // ==========================================================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (taken |=> ack_o)
    else $error("request not acked after one cycle");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_NO_REQ: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  AST_FCR_WR: assert property (fcr_wr |=> fifo_control_wr_o)
    else $error("fifo control write strobe missing");
  AST_FCR_DATA: assert property (
    fcr_wr |=> fifo_control_o == $past(dat_i[7:0]))
    else $error("fifo control byte wrong");
  AST_EVT_RSV: assert property (ack_o && rd_evt && !ext |->
    dat_o[5:4] == 2'h0 && (dat_o[7:6] == 2'h0 || dat_o[7:6] == 2'h3))
    else $error("event byte upper bits wrong");
  AST_TO_BIT: assert property (
    ack_o && rd_evt && !ext && !fifo_control_o[0] |-> !dat_o[3])
    else $error("timeout bit set without fifos");
  AST_IER_RSV: assert property (ack_o && rd_ier |->
    dat_o[7:6] == 2'h0 && (ext || dat_o[5:4] == 2'h0))
    else $error("enable reserved bits set");
  cover property (ack_o && rd_evt);
  cover property ($rose(irq_o));
  cover property (fifo_control_wr_o);
endmodule

bind serial_ir_interrupt_event_unit irq_event_checker checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .fifo_control_o(fifo_control_o),
  .fifo_control_wr_o(fifo_control_wr_o), .irq_o(irq_o));

// ### tb/host_model.sv
// host_model: classic wishbone master doing single register cycles
// assumes the slave answers each request with ack
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [3:0]       sel_o,
  output logic [3:0]       adr_o,
  output logic [31:0]      dat_o
);
  initial {cyc_o, stb_o, we_o, sel_o, adr_o, dat_o} = '0;
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o} <= {2'b11, w};
    sel_o <= 4'h1;
    adr_o <= a;
    dat_o <= {24'h0, d};
    // ack and read data are taken at the rising edge that samples ack
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o} <= 2'b00;
  endtask
endmodule

// ### tb/tb.sv
// tb: self-checking bench for the serial interrupt event unit
// assumes host_model drives the register bus
`timescale 1ns/1ps
module tb;
  import irq_event_pkg::*;
  localparam src_t line_m = 15'h0008;
  localparam src_t modem_m = 15'h0002;
  localparam src_t dma_m = 15'h0001;
  localparam src_t under_m = 15'h0004;
  localparam src_t tick_m = 15'h0800;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         ldma = 1'b0;
  logic         cyc, stb, we, ack, fwr, irq;
  logic [3:0]   sel, adr;
  logic [7:0]   fifo_control;
  logic [31:0]  wdat, rdat, q;
  logic [31:0]  r = 32'hff23;
  src_t         src = 15'h0180;
  port_access_t acc = '0;
  int           n_errors = 0;
  int           checked = 0;
  int           cycles = 0;
  host_model host_model_i (.clk_i(clk), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr),
    .dat_o(wdat));
  serial_ir_interrupt_event_unit serial_ir_interrupt_event_unit_i (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .src_i(src), .acc_i(acc), .legacy_dma_i(ldma),
    .fifo_control_o(fifo_control), .fifo_control_wr_o(fwr), .irq_o(irq));
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ==========================================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] evt(input logic fifo, logic [3:0] c);
    return {fifo ? 2'h3 : 2'h0, 2'h0, c};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    host_model_i.xfer(1'b0, a, 8'h00, q);
    chk("register", q, {24'h0, e});
  endtask
  task automatic ps(input src_t m);
    @(posedge clk) src <= src | m;
    @(posedge clk) src <= src & ~m;
  endtask
  task automatic pa(input port_access_t m);
    @(posedge clk) acc <= m;
    @(posedge clk) acc <= '0;
  endtask
  task automatic irq_is(input logic e);
    @(negedge clk) chk("irq", {31'h0, irq}, {31'h0, e});
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(addr_enable_c, 8'h00);
    rd(addr_event_c, code_none_c);
    wr(addr_enable_c, 8'hff);
    rd(addr_enable_c, 8'h0f);
    rd(4'h0, 8'h00);
    ps(line_m | modem_m);
    rd(addr_event_c, code_line_c);
    irq_is(1'b1);
    pa(4'h2);
    rd(addr_event_c, code_modem_c);
    pa(4'h1);
    rd(addr_event_c, code_none_c);
    irq_is(1'b0);
    $display("test priority done");
    @(posedge clk) src.thr_empty <= 1'b1;
    wr(addr_enable_c, 8'h02);
    rd(addr_event_c, code_tx_c);
    rd(addr_event_c, code_none_c);
    @(posedge clk) src.thr_empty <= 1'b0;
    pa(4'h4);
    rd(addr_event_c, code_none_c);
    @(posedge clk) src.rx_full <= 1'b1;
    wr(addr_enable_c, 8'h01);
    rd(addr_event_c, code_rx_c);
    wr(addr_event_c, 8'h01);
    rd(addr_event_c, evt(1'b1, code_rx_c));
    @(posedge clk) {src.rx_full, src.rx_char_held} <= 2'b01;
    repeat (3) ps(tick_m);
    rd(addr_event_c, evt(1'b1, code_none_c));
    ps(tick_m);
    rd(addr_event_c, evt(1'b1, code_timeout_c));
    pa(4'h8);
    rd(addr_event_c, evt(1'b1, code_none_c));
    @(posedge clk) src.rx_char_held <= 1'b0;
    $display("test legacy sources done");
    wr(addr_event_c, 8'h00);
    @(posedge clk) ldma <= 1'b1;
    wr(addr_mode_c, 8'h05);
    wr(addr_enable_c, 8'h00);
    ps(line_m | dma_m);
    rd(addr_event_c, 8'h14);
    irq_is(1'b0);
    wr(addr_enable_c, 8'hff);
    rd(addr_enable_c, 8'h3f);
    irq_is(1'b1);
    rd(addr_event_c, 8'h04);
    pa(4'h2);
    @(posedge clk) src.thr_empty <= 1'b1;
    rd(addr_event_c, 8'h02);
    @(posedge clk) src.thr_empty <= 1'b0;
    wr(addr_mode_c, 8'h0b);
    ps(under_m);
    rd(addr_event_c, 8'h04);
    pa(4'h2);
    wr(addr_mode_c, 8'h03);
    ps(under_m);
    rd(addr_event_c, 8'h00);
    wr(addr_mode_c, 8'h00);
    rd(addr_enable_c, 8'h0f);
    $display("test extended done");
    @(posedge clk) src.tx_level <= 5'h10;
    for (int i = 0; i < 6; i++) begin
      r = lfsr(r);
      wr(addr_enable_c, r[7:0]);
      wr(addr_event_c, r[15:8]);
      chk("fifo control", {24'h0, fifo_control}, {24'h0, r[15:8]});
      rd(addr_enable_c, r[7:0] & ier_legacy_mask_c);
      rd(addr_event_c, evt(r[8], code_none_c));
    end
    $display("test random done");
    end_of_test();
  end
endmodule
